// File: logic/lcdc_regs.sv
// Overview of operation
// - booster follows booster enable bit
// - bias select 1 quarter, 0 third
// - heavy-load bit sets regulator protection mode
// - output select 1 picks second level
// - regulator enable bit switches regulator
// - segment direction 1 normal, 0 reversed
// - common direction 1 normal, 0 reversed
// - inversion bit 0 inverts every pixel
// - area select picks display memory area
// - two-bit display mode field, resets zero
// - 24 common drive enables, reset ones
// - frame flag reads 1 after frame
// - writing 1 clears flag, 0 ignored
// - frame enable bit, resets to zero
// - irq only when flag and enable
// - module disable while on forces mode zero
`include "lcdc_params.svh"

module lcdc_regs #(
  parameter int ADDR_W = 12,
  parameter int NSEG   = 72,
  parameter int NCOM   = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  input  wire logic              frame_switch_i,
  input  wire logic              fetch_req_i,
  input  wire logic [6:0]        fetch_seg_i,
  input  wire logic [4:0]        fetch_com_i,
  input  wire logic              pixel_i,
  output logic                   module_en_o,
  output logic                   booster_en_o,
  output logic                   bias_quarter_o,
  output logic                   heavy_load_o,
  output logic                   reg_out_sel_o,
  output logic                   regulator_en_o,
  output logic [4:0]             contrast_o,
  output logic                   seg_dir_o,
  output logic                   com_dir_o,
  output logic                   disp_normal_o,
  output logic                   area_sel_o,
  output logic [1:0]             display_mode_o,
  output logic [23:0]            com_drive_en_o,
  output logic [6:0]             phys_seg_o,
  output logic [4:0]             phys_com_o,
  output logic                   phys_area_o,
  output logic                   com_off_o,
  output logic                   pixel_o,
  output logic                   frame_flag_o,
  output logic                   irq_o
);
  localparam logic [6:0] SEG_LAST = 7'(NSEG - 1);
  localparam logic [4:0] COM_LAST = 5'(NCOM - 1);

  lcdc_reg_if regif ();

  lcdc_pkg::lcdc_half_t lcd_power_control;
  lcdc_pkg::lcdc_half_t lcd_display_control;
  lcdc_pkg::lcdc_half_t common_partial_drive_low;
  lcdc_pkg::lcdc_half_t common_partial_drive_high;
  lcdc_pkg::lcdc_half_t rdata;
  lcdc_pkg::lcdc_mode_t next_mode;
  logic                 frame_irq_enable;
  logic                 wr_ctl;
  logic                 wr_pwr;
  logic                 wr_dsp;
  logic                 wr_c0;
  logic                 wr_c1;
  logic                 mod_off;

  ////////////////////////////////////////////////////////////////////////////
  lcdc_apb_slave #(
    .ADDR_W (ADDR_W)
  ) u_apb (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .pready_o  (pready_o),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o),
    .regif     (regif.apb)
  );

  lcdc_frame_irq u_frame (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .frame_set_i (frame_switch_i),
    .flag_wr_i   (regif.wr_en && regif.idx == `LCDC_IDX_INTF),
    .enable_wr_i (regif.wr_en && regif.idx == `LCDC_IDX_INTE),
    .wbit_i      (regif.wdata[`LCDC_BIT_FRM]),
    .flag_o      (frame_flag_o),
    .enable_o    (frame_irq_enable),
    .irq_o       (irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign wr_ctl = regif.wr_en && regif.idx == `LCDC_IDX_CTL;
  assign wr_pwr = regif.wr_en && regif.idx == `LCDC_IDX_PWR;
  assign wr_dsp = regif.wr_en && regif.idx == `LCDC_IDX_DSP;
  assign wr_c0  = regif.wr_en && regif.idx == `LCDC_IDX_COMC0;
  assign wr_c1  = regif.wr_en && regif.idx == `LCDC_IDX_COMC1;

  // module enable falling 1 to 0 by software write
  assign mod_off = wr_ctl && module_en_o
                && !regif.wdata[`LCDC_BIT_MODULE_ENABLE];

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      module_en_o <= 1'b0;
    end else if (wr_ctl) begin
      module_en_o <= regif.wdata[`LCDC_BIT_MODULE_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power controls; reserved bits never stored
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lcd_power_control <= `LCDC_RST_PWR;
    end else if (wr_pwr) begin
      lcd_power_control <= regif.wdata & `LCDC_MASK_PWR;
    end
  end

  // output select is not guarded: external supply mode is software's care
  assign booster_en_o   = lcd_power_control[`LCDC_BIT_BOOSTER_ENABLE];
  assign bias_quarter_o = lcd_power_control[`LCDC_BIT_BIAS_SELECT];
  assign heavy_load_o   = lcd_power_control[`LCDC_BIT_HEAVY_LOAD_MODE];
  assign reg_out_sel_o  = lcd_power_control[`LCDC_BIT_REGULATOR_OUTPUT_SELECT];
  assign regulator_en_o = lcd_power_control[`LCDC_BIT_REGULATOR_ENABLE];
  assign contrast_o     =
    lcd_power_control[`LCDC_MSB_LC:`LCDC_LSB_LC];

  ////////////////////////////////////////////////////////////////////////////
  // display control; a disabling write overrides a mode write
  always_comb begin
    next_mode = display_mode_o;
    if (wr_dsp) begin
      next_mode = regif.wdata[`LCDC_MSB_MODE:`LCDC_LSB_MODE];
    end
    if (mod_off && display_mode_o != 2'h0) begin
      next_mode = 2'h0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lcd_display_control <= `LCDC_RST_DSP;
    end else if (wr_dsp) begin
      lcd_display_control <= regif.wdata & `LCDC_MASK_DSP;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      display_mode_o <= 2'h0;
    end else begin
      display_mode_o <= next_mode;
    end
  end

  assign seg_dir_o     = lcd_display_control[`LCDC_BIT_SEGDIR];
  assign com_dir_o     = lcd_display_control[`LCDC_BIT_COMDIR];
  assign disp_normal_o = lcd_display_control[`LCDC_BIT_INV];
  assign area_sel_o    = lcd_display_control[`LCDC_BIT_AREA];

  ////////////////////////////////////////////////////////////////////////////
  // partial drive enables, one per common
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      common_partial_drive_low  <= `LCDC_RST_COMC0;
      common_partial_drive_high <= `LCDC_RST_COMC1;
    end else begin
      if (wr_c0) begin
        common_partial_drive_low <= regif.wdata;
      end
      if (wr_c1) begin
        common_partial_drive_high <= regif.wdata & `LCDC_MASK_COMC1;
      end
    end
  end

  assign com_drive_en_o = {common_partial_drive_high[7:0],
                           common_partial_drive_low};

  ////////////////////////////////////////////////////////////////////////////
  // pixel fetch mapping, one cycle behind the request
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      phys_seg_o  <= 7'h00;
      phys_com_o  <= 5'h00;
      phys_area_o <= 1'b0;
      com_off_o   <= 1'b0;
    end else if (fetch_req_i) begin
      phys_seg_o  <= seg_dir_o ? fetch_seg_i
                               : SEG_LAST - fetch_seg_i;
      phys_com_o  <= com_dir_o ? fetch_com_i
                               : COM_LAST - fetch_com_i;
      phys_area_o <= area_sel_o;
      // commons above 23 do not exist and read as driven off
      com_off_o   <= (fetch_com_i > 5'd23) ? 1'b1
                   : !com_drive_en_o[fetch_com_i];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pixel_o <= 1'b0;
    end else begin
      pixel_o <= disp_normal_o ? pixel_i : !pixel_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back; unmapped and reserved bits give zero
  always_comb begin
    case (regif.idx)
      `LCDC_IDX_CTL:   rdata = {15'h0000, module_en_o};
      `LCDC_IDX_PWR:   rdata = lcd_power_control;
      `LCDC_IDX_DSP:   rdata = {lcd_display_control[15:2],
                                display_mode_o};
      `LCDC_IDX_COMC0: rdata = common_partial_drive_low;
      `LCDC_IDX_COMC1: rdata = common_partial_drive_high;
      `LCDC_IDX_INTF:  rdata = {15'h0000, frame_flag_o};
      `LCDC_IDX_INTE:  rdata = {15'h0000, frame_irq_enable};
      default:         rdata = 16'h0000;
    endcase
  end

  assign regif.rdata = rdata;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  booster_write_a: assert property (
    wr_pwr |=> booster_en_o == $past(regif.wdata[`LCDC_BIT_BOOSTER_ENABLE]))
    else $error("booster enable did not follow write");
  bias_hold_a: assert property (
    !wr_pwr |=> $stable(bias_quarter_o))
    else $error("bias select changed without write");
  heavy_load_a: assert property (
    wr_pwr ##1 !wr_pwr |->
      heavy_load_o == $past(regif.wdata[`LCDC_BIT_HEAVY_LOAD_MODE]))
    else $error("heavy load mode lost");
  vc_select_a: assert property (
    wr_pwr |=> reg_out_sel_o == $past(regif.wdata[`LCDC_BIT_REGULATOR_OUTPUT_SELECT]))
    else $error("regulator output select wrong");
  regulator_on_a: assert property (
    wr_pwr |=> regulator_en_o == $past(regif.wdata[`LCDC_BIT_REGULATOR_ENABLE]))
    else $error("regulator enable wrong");
  seg_map_a: assert property (
    fetch_req_i |=> phys_seg_o == ($past(seg_dir_o) ? $past(fetch_seg_i)
                                   : SEG_LAST - $past(fetch_seg_i)))
    else $error("segment mapping wrong");
  com_map_a: assert property (
    fetch_req_i |=> phys_com_o == ($past(com_dir_o) ? $past(fetch_com_i)
                                   : COM_LAST - $past(fetch_com_i)))
    else $error("common mapping wrong");
  pixel_invert_a: assert property (
    rst_n_i |=> pixel_o == ($past(pixel_i) ^ !$past(disp_normal_o)))
    else $error("pixel inversion wrong");
  area_fetch_a: assert property (
    fetch_req_i |=> phys_area_o == $past(area_sel_o))
    else $error("display area wrong");
  mode_off_a: assert property (
    mod_off |=> display_mode_o == 2'h0 && !module_en_o)
    else $error("display not forced off");
  com_drive_a: assert property (
    wr_c1 |=> com_drive_en_o[23:16] == $past(regif.wdata[7:0]))
    else $error("partial drive high byte wrong");
  reserved_zero_a: assert property (
    regif.idx == `LCDC_IDX_DSP |-> rdata[15:7] == 9'h000 && !rdata[3])
    else $error("reserved display bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // write-follow and hold checks for the remaining fields
  bias_write_a: assert property (
    wr_pwr |=> bias_quarter_o == $past(regif.wdata[`LCDC_BIT_BIAS_SELECT]))
    else $error("bias select did not follow write");
  power_hold_a: assert property (
    !wr_pwr |=> $stable(lcd_power_control))
    else $error("power control changed without write");
  dir_write_a: assert property (
    wr_dsp |=> seg_dir_o == $past(regif.wdata[`LCDC_BIT_SEGDIR])
            && com_dir_o == $past(regif.wdata[`LCDC_BIT_COMDIR]))
    else $error("direction bits did not follow write");
  inv_write_a: assert property (
    wr_dsp |=> disp_normal_o == $past(regif.wdata[`LCDC_BIT_INV]))
    else $error("inversion bit did not follow write");
  area_write_a: assert property (
    wr_dsp |=> area_sel_o == $past(regif.wdata[`LCDC_BIT_AREA]))
    else $error("area select did not follow write");
  mode_write_a: assert property (
    wr_dsp |=>
      display_mode_o == $past(regif.wdata[`LCDC_MSB_MODE:`LCDC_LSB_MODE]))
    else $error("display mode did not follow write");
  mode_hold_a: assert property (
    !wr_dsp && !mod_off |=> $stable(display_mode_o))
    else $error("display mode changed without cause");
  com_low_a: assert property (
    wr_c0 |=> com_drive_en_o[15:0] == $past(regif.wdata))
    else $error("partial drive low half wrong");
  com_hold_a: assert property (
    !wr_c0 && !wr_c1 |=> $stable(com_drive_en_o))
    else $error("partial drive changed without write");
  com_off_a: assert property (
    fetch_req_i && fetch_com_i < 5'd24 |=>
      com_off_o == !$past(com_drive_en_o[fetch_com_i]))
    else $error("off waveform select wrong");
  flag_hold_a: assert property (
    !frame_switch_i && !(regif.wr_en && regif.idx == `LCDC_IDX_INTF)
      |=> $stable(frame_flag_o))
    else $error("frame flag changed without cause");
  enable_write_a: assert property (
    regif.wr_en && regif.idx == `LCDC_IDX_INTE
      |=> frame_irq_enable == $past(regif.wdata[`LCDC_BIT_FRM]))
    else $error("frame enable did not follow write");
  irq_gate_a: assert property (
    irq_o |-> frame_flag_o && frame_irq_enable)
    else $error("irq without flag and enable");
  module_write_a: assert property (
    wr_ctl |=> module_en_o == $past(regif.wdata[`LCDC_BIT_MODULE_ENABLE]))
    else $error("module enable did not follow write");
  pwr_reserved_a: assert property (
    regif.idx == `LCDC_IDX_PWR |-> (rdata & ~`LCDC_MASK_PWR) == 16'h0000)
    else $error("reserved power bits not zero");
  c1_reserved_a: assert property (
    regif.idx == `LCDC_IDX_COMC1 |-> rdata[15:8] == 8'h00)
    else $error("reserved drive bits not zero");
  bad_write_a: assert property (
    pslverr_o |-> !regif.wr_en)
    else $error("unmapped write reached a register");
endmodule

// File: logic/lcdc_params.svh
`ifndef LCDC_PARAMS_SVH
`define LCDC_PARAMS_SVH

// register index, byte address is four times the index
`define LCDC_IDX_CTL       3'h0
`define LCDC_IDX_PWR       3'h1
`define LCDC_IDX_DSP       3'h2
`define LCDC_IDX_COMC0     3'h3
`define LCDC_IDX_COMC1     3'h4
`define LCDC_IDX_INTF      3'h5
`define LCDC_IDX_INTE      3'h6
`define LCDC_IDX_LAST      3'h6

// reset values
`define LCDC_RST_CTL       16'h0000
`define LCDC_RST_PWR       16'h0008
`define LCDC_RST_DSP       16'h0070
`define LCDC_RST_COMC0     16'hffff
`define LCDC_RST_COMC1     16'h00ff

// writable bit masks, everything else reads zero
`define LCDC_MASK_CTL      16'h0001
`define LCDC_MASK_PWR      16'h1f1f
`define LCDC_MASK_DSP      16'h0077
`define LCDC_MASK_COMC1    16'h00ff

// field positions
`define LCDC_BIT_MODULE_ENABLE     0
`define LCDC_BIT_REGULATOR_ENABLE      0
`define LCDC_BIT_REGULATOR_OUTPUT_SELECT     1
`define LCDC_BIT_HEAVY_LOAD_MODE      2
`define LCDC_BIT_BIAS_SELECT     3
`define LCDC_BIT_BOOSTER_ENABLE     4
`define LCDC_LSB_LC        8
`define LCDC_MSB_LC        12
`define LCDC_LSB_MODE      0
`define LCDC_MSB_MODE      1
`define LCDC_BIT_AREA      2
`define LCDC_BIT_INV       4
`define LCDC_BIT_COMDIR    5
`define LCDC_BIT_SEGDIR    6
`define LCDC_BIT_FRM       0

`endif

// File: logic/lcdc_pkg.sv
package lcdc_pkg;
  typedef logic [2:0]  lcdc_idx_t;
  typedef logic [15:0] lcdc_half_t;
  typedef logic [1:0]  lcdc_mode_t;
endpackage

// File: logic/lcdc_reg_if.sv
interface lcdc_reg_if;
  logic                 wr_en;
  lcdc_pkg::lcdc_idx_t  idx;
  lcdc_pkg::lcdc_half_t wdata;
  lcdc_pkg::lcdc_half_t rdata;

  modport apb  (output wr_en, output idx, output wdata, input rdata);
  modport regs (input wr_en, input idx, input wdata, output rdata);
endinterface

// File: logic/lcdc_apb_slave.sv
`include "lcdc_params.svh"

module lcdc_apb_slave #(
  parameter int ADDR_W = 12
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  lcdc_reg_if.apb                regif
);
  logic hit;
  logic access;

  // aligned word inside the seven-register window
  assign hit = (paddr_i[ADDR_W-1:5] == '0) && (paddr_i[1:0] == 2'b00)
            && (paddr_i[4:2] <= `LCDC_IDX_LAST);
  assign access = psel_i && penable_i;

  assign regif.idx   = paddr_i[4:2];
  assign regif.wdata = pwdata_i[15:0];
  // the write lands on the completing edge only
  assign regif.wr_en = access && pready_o && pwrite_i && hit;

  ////////////////////////////////////////////////////////////////////////////
  // one wait state: pready rises on the second access cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (access && !pready_o) begin
      pready_o  <= 1'b1;
      prdata_o  <= (hit && !pwrite_i) ? {16'h0000, regif.rdata}
                                      : 32'h0000_0000;
      pslverr_o <= !hit;
    end else begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end
endmodule

// File: logic/lcdc_frame_irq.sv
`include "lcdc_params.svh"

module lcdc_frame_irq (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic frame_set_i,
  input  wire logic flag_wr_i,
  input  wire logic enable_wr_i,
  input  wire logic wbit_i,
  output logic      flag_o,
  output logic      enable_o,
  output logic      irq_o
);
  logic next_flag;
  logic next_enable;

  always_comb begin
    next_flag = flag_o;
    if (flag_wr_i && wbit_i) begin
      next_flag = 1'b0;
    end
    // a frame switch in the clearing cycle is kept
    if (frame_set_i) begin
      next_flag = 1'b1;
    end
    next_enable = enable_wr_i ? wbit_i : enable_o;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flag_o   <= 1'b0;
      enable_o <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      flag_o   <= next_flag;
      enable_o <= next_enable;
      irq_o    <= next_flag && next_enable;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  set_wins_a: assert property (
    frame_set_i |=> flag_o)
    else $error("frame flag lost on a clear");
  clear_one_a: assert property (
    flag_wr_i && wbit_i && !frame_set_i |=> !flag_o)
    else $error("write 1 did not clear flag");
  irq_pair_a: assert property (
    ##1 irq_o == (flag_o && enable_o))
    else $error("irq disagrees with flag and enable");
endmodule

// File: tb/lcdc_wave_model.sv
module lcdc_wave_model (
  input  wire logic mclk_i,
  output logic       frame_switch_o = 1'b0,
  output logic       fetch_req_o = 1'b0,
  output logic [6:0] fetch_seg_o = 7'h00,
  output logic [4:0] fetch_com_o = 5'h00,
  output logic       pixel_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // memory bit keeps moving so a stale sample cannot pass
  logic [7:0] lfsr = 8'h5a;

  always @(posedge mclk_i) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    pixel_o <= lfsr[0];
  end

  task automatic frame();
    @(posedge mclk_i);
    frame_switch_o <= 1'b1;
    @(posedge mclk_i);
    frame_switch_o <= 1'b0;
  endtask

  task automatic fetch(input logic [6:0] s, input logic [4:0] c);
    @(posedge mclk_i);
    fetch_req_o <= 1'b1;
    fetch_seg_o <= s;
    fetch_com_o <= c;
    @(posedge mclk_i);
    fetch_req_o <= 1'b0;
  endtask
endmodule

// File: tb/tb_top.sv
`include "lcdc_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCOM = 8;
  logic        mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, r;
  logic        pready_o, pslverr_o, frame_switch_i, fetch_req_i, pixel_i;
  logic [6:0]  fetch_seg_i, phys_seg_o;
  logic [4:0]  fetch_com_i, phys_com_o, contrast_o;
  logic        module_en_o, booster_en_o, bias_quarter_o, heavy_load_o;
  logic        reg_out_sel_o, regulator_en_o, seg_dir_o, com_dir_o;
  logic        disp_normal_o, area_sel_o, phys_area_o, com_off_o, pixel_o;
  logic        frame_flag_o, irq_o, e, p1, pn, pv = 0;
  logic [1:0]  display_mode_o;
  logic [23:0] com_drive_en_o;
  logic [15:0] m [7];
  logic [42:0] got_pins;
  int          n_fail = 0, checked = 0, cyc = 0, seed_v;

  always #12.5 mclk_i = ~mclk_i;

  lcdc_regs #(.ADDR_W(12), .NSEG(72), .NCOM(NCOM)) i_lcdc_regs (
    .mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .frame_switch_i,
    .fetch_req_i, .fetch_seg_i, .fetch_com_i, .pixel_i, .module_en_o,
    .booster_en_o, .bias_quarter_o, .heavy_load_o, .reg_out_sel_o,
    .regulator_en_o, .contrast_o, .seg_dir_o, .com_dir_o, .disp_normal_o,
    .area_sel_o, .display_mode_o, .com_drive_en_o, .phys_seg_o,
    .phys_com_o, .phys_area_o, .com_off_o, .pixel_o, .frame_flag_o, .irq_o);

  lcdc_wave_model i_lcdc_wave_model (
    .mclk_i, .frame_switch_o(frame_switch_i), .fetch_req_o(fetch_req_i),
    .fetch_seg_o(fetch_seg_i), .fetch_com_o(fetch_com_i),
    .pixel_o(pixel_i));

  assign got_pins = {module_en_o, booster_en_o, bias_quarter_o,
    heavy_load_o, reg_out_sel_o, regulator_en_o, contrast_o, seg_dir_o,
    com_dir_o, disp_normal_o, area_sel_o, display_mode_o, com_drive_en_o,
    frame_flag_o, irq_o};

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic chk_pin(input logic [63:0] g, input logic [63:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  function automatic logic [42:0] exp_pins();
    return {m[0][0], m[1][4], m[1][3], m[1][2], m[1][1], m[1][0],
      m[1][12:8], m[2][6], m[2][5], m[2][4], m[2][2], m[2][1:0],
      m[4][7:0], m[3], m[5][0], m[5][0] & m[6][0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // pready and read data are taken at the completing edge
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40)
      n_fail++;
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic wr(input int i, input logic [15:0] d);
    bus(1'b1, 12'(i * 4), {16'h0000, d});
    chk_rd({31'h0, e}, 32'h0000_0000);
    case (i)
      0: begin
        // disable while showing blanks the mode field
        if (m[0][0] && !d[0])
          m[2][1:0] = 2'h0;
        m[0] = d & `LCDC_MASK_CTL;
      end
      1: m[1] = d & `LCDC_MASK_PWR;
      2: m[2] = d & `LCDC_MASK_DSP;
      3: m[3] = d;
      4: m[4] = d & `LCDC_MASK_COMC1;
      5: m[5] = d[0] ? 16'h0000 : m[5];
      default: m[6] = d & 16'h0001;
    endcase
    chk_pin(got_pins, exp_pins());
  endtask

  task automatic rd(input int i);
    bus(1'b0, 12'(i * 4), 32'h0000_0000);
    chk_rd(r, {16'h0000, m[i]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(negedge mclk_i) begin
    if (rst_n_i && pv && disp_normal_o === pn)
      chk_pin(64'(pixel_o), 64'(p1 ^ !pn));
    p1 <= pixel_i;
    pn <= disp_normal_o;
    pv <= rst_n_i;
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    logic [6:0] s;
    logic [4:0] c;
    logic [23:0] en;
    m = '{`LCDC_RST_CTL, `LCDC_RST_PWR, `LCDC_RST_DSP, `LCDC_RST_COMC0,
          `LCDC_RST_COMC1, 16'h0000, 16'h0000};
    seed_v = $urandom(32'h97b8);
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    chk_pin(got_pins, exp_pins());
    for (int i = 0; i < 7; i++) rd(i);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 7; i++) begin
        wr(i, 16'($urandom));
        rd(i);
      end
    $display("test random access done");
    bus(1'b1, 12'h01c, 32'hffff_ffff);
    chk_rd({31'h0, e}, 32'h0000_0001);
    bus(1'b0, 12'h006, 32'h0000_0000);
    chk_rd({r[30:0], e}, 32'h0000_0001);
    bus(1'b1, 12'h024, 32'h0000_0000);
    chk_rd({31'h0, e}, 32'h0000_0001);
    for (int i = 0; i < 7; i++) rd(i);
    $display("test unmapped done");
    wr(0, 16'h0001);
    wr(2, 16'h0073);
    wr(0, 16'h0000);
    rd(2);
    $display("test module disable done");
    // external supply: regulator off, output select kept at 0
    wr(1, 16'h0000);
    wr(6, 16'h0000);
    wr(5, 16'h0001);
    i_lcdc_wave_model.frame();
    m[5] = 16'h0001;
    @(negedge mclk_i);
    chk_pin(got_pins, exp_pins());
    rd(5);
    wr(5, 16'hfffe);
    wr(6, 16'h0001);
    wr(5, 16'h0001);
    rd(5);
    $display("test frame flag done");
    en = {m[4][7:0], m[3]};
    for (int k = 0; k < 4; k++) begin
      wr(2, {9'h000, k[0], k[1], ~k[0], 1'b0, k[1], 2'h1});
      for (int j = 0; j < 3; j++) begin
        s = 7'($urandom % 72);
        c = (k == 3 && j == 2) ? 5'h18 : 5'($urandom % NCOM);
        i_lcdc_wave_model.fetch(s, c);
        @(negedge mclk_i);
        chk_pin({phys_seg_o, phys_com_o, phys_area_o, com_off_o},
          {k[0] ? s : 7'(71 - s), k[1] ? c : 5'(NCOM - 1 - c), k[1],
           (c > 5'h17) || !en[c]});
      end
    end
    $display("test fetch mapping done");
    summarize();
  end
endmodule
